// ==== sms_params.svh ====
// constants shared by both ends of the serial management port
// assumes it is included by bare name from the device end and host end design files
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH

// strap encodings of the port mode
`define SMS_MODE_SPI 2'h0
`define SMS_MODE_I2C 2'h1
`define SMS_MODE_MIIM 2'h2

// spi frame: 27 command/address bits, 5 turnaround bits, 8 data bits
`define SMS_CMD_READ 3'h3
`define SMS_CMD_WRITE 3'h2
`define SMS_CMD_END 6'h1A
`define SMS_DATA_START 6'h20
`define SMS_BYTE_LAST 6'h27
`define SMS_ADDR_PAD 8'h00
`define SMS_TA_PAD 5'h00

// i2c framing
`define SMS_I2C_ADDR 7'h5F
`define SMS_ACK_SLOT 4'h8
`define SMS_IDX_ADDR_HI 3'h1
`define SMS_IDX_ADDR_LO 3'h2
`define SMS_IDX_THIRD 3'h3
`define SMS_IDX_READ 3'h4

// host bit timing: four phases per bit
`define SMS_PH_DRIVE 2'h1
`define SMS_PH_RISE 2'h2
`define SMS_PH_LAST 2'h3

`endif

// ==== sms_pkg.sv ====
// types shared by both ends of the serial management port
// assumes nothing beyond a SystemVerilog compiler
package sms_pkg;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_HI, I2C_ADDR_LO, I2C_WDATA, I2C_RDATA
  } sms_i2c_st_t;

  typedef enum logic [2:0] {
    H_IDLE, H_SPI, H_START, H_BYTE, H_STOP, H_DONE
  } sms_host_st_t;

endpackage : sms_pkg

// ==== sms_link_if.sv ====
// pins between the management host and the device port
// assumes an external pull-up on the open-drain data line and on an undriven sdo
`timescale 1ns/10ps
`default_nettype none

interface sms_link_if;
  logic sck;
  logic csN;
  logic serial_data_in;
  logic devSdo;
  logic sdoOe;
  logic sdoLine;
  logic devSdaOut;
  logic devSdaOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic sda;

  // wired resolution: a driver pulls low only when enabled and driving zero
  assign sdoLine = sdoOe ? devSdo : 1'b1;
  assign sda = !((devSdaOe && !devSdaOut) || (hostSdaOe && !hostSdaOut));

  modport dev (input sck, csN, serial_data_in, sda, output devSdo, sdoOe, devSdaOut, devSdaOe);
  modport host (input sdoLine, sda, output sck, csN, serial_data_in, hostSdaOut, hostSdaOe);
endinterface : sms_link_if

`default_nettype wire

// ==== sms_dev_end.sv ====
// device end of the serial management port: spi or i2c slave into 8-bit registers
// assumes pins synchronous to clk_sys and each serial clock half period >= 4 clk_sys
`timescale 1ns/10ps
`default_nettype none
`include "sms_params.svh"

module sms_dev_end (
  input wire logic clk_sys,          // system clock
  input wire logic resetn,           // synchronous reset, active low
  input wire logic clkEn,            // freezes all state while low
  input wire logic [1:0] modeStrap,  // mode strap level
  input wire logic [7:0] regRdata,   // register read data, valid while regRd is high
  output logic [15:0] regAddr,       // register address
  output logic [7:0] regWdata,       // register write data
  output logic regWr,                // write strobe, one cycle
  output logic regRd,                // read strobe, one cycle
  output logic [1:0] portMode,       // mode in force
  sms_link_if.dev lnk                // serial pins
);

  logic [1:0] mode_q, mode_d;
  logic strapDone_q, strapDone_d;
  logic sckPrev_q, sckPrev_d;
  logic sdaPrev_q, sdaPrev_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [15:0] ptr_q, ptr_d;
  logic [15:0] regAddr_q, regAddr_d;
  logic [7:0] regWdata_q, regWdata_d;
  logic regWr_q, regWr_d;
  logic regRd_q, regRd_d;
  logic [7:0] rdBuf_q, rdBuf_d;
  logic isRead_q, isRead_d;
  logic isWrite_q, isWrite_d;
  logic nack_q, nack_d;
  logic sdo_q, sdo_d;
  logic sdoOe_q, sdoOe_d;
  logic sdaOe_q, sdaOe_d;
  sms_pkg::sms_i2c_st_t ist_q, ist_d;

  logic sckRise;
  logic sckFall;
  logic i2cStart;
  logic i2cStop;

  assign sckRise = !sckPrev_q && lnk.sck;
  assign sckFall = sckPrev_q && !lnk.sck;
  assign i2cStart = sckPrev_q && lnk.sck && sdaPrev_q && !lnk.sda;
  assign i2cStop = sckPrev_q && lnk.sck && !sdaPrev_q && lnk.sda;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] newSh;
    logic [7:0] rxByte;
    newSh = {sh_q[30:0], lnk.serial_data_in};
    rxByte = sh_q[7:0];
    mode_d = mode_q;
    strapDone_d = strapDone_q;
    sckPrev_d = lnk.sck;
    sdaPrev_d = lnk.sda;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    regAddr_d = regAddr_q;
    regWdata_d = regWdata_q;
    regWr_d = 1'b0;
    regRd_d = 1'b0;
    // read data is taken in the strobe cycle, so the register file answers combinationally
    rdBuf_d = regRd_q ? regRdata : rdBuf_q;
    isRead_d = isRead_q;
    isWrite_d = isWrite_q;
    nack_d = nack_q;
    sdo_d = sdo_q;
    sdoOe_d = sdoOe_q;
    sdaOe_d = sdaOe_q;
    ist_d = ist_q;
    if (!strapDone_q) begin
      mode_d = modeStrap;
      strapDone_d = 1'b1;
    end else begin
      case (mode_q)
        `SMS_MODE_SPI: begin
          if (lnk.csN) begin
            // select high ends the frame: nothing partial survives
            cnt_d = 6'h00;
            isRead_d = 1'b0;
            isWrite_d = 1'b0;
            sdoOe_d = 1'b0;
          end else if (sckRise) begin
            sh_d = newSh;
            cnt_d = (cnt_q == `SMS_BYTE_LAST) ? `SMS_DATA_START : cnt_q + 6'h01;
            if (cnt_q == `SMS_CMD_END) begin
              // upper address byte dropped on purpose
              ptr_d = newSh[15:0];
              regAddr_d = newSh[15:0];
              isRead_d = (newSh[26:24] == `SMS_CMD_READ);
              isWrite_d = (newSh[26:24] == `SMS_CMD_WRITE);
              regRd_d = (newSh[26:24] == `SMS_CMD_READ);
            end
            // turnaround bits shift through and are never looked at
            if (cnt_q == `SMS_BYTE_LAST) begin
              if (isWrite_q) begin
                regWr_d = 1'b1;
                regAddr_d = ptr_q;
                regWdata_d = newSh[7:0];
                ptr_d = ptr_q + 16'h0001;
              end else if (isRead_q) begin
                regRd_d = 1'b1;
                regAddr_d = ptr_q + 16'h0001;
                ptr_d = ptr_q + 16'h0001;
              end
            end
          end else if (sckFall && isRead_q && cnt_q >= `SMS_DATA_START) begin
            if (cnt_q == `SMS_DATA_START) begin
              tx_d = rdBuf_q;
              sdo_d = rdBuf_q[7];
              sdoOe_d = 1'b1;
            end else begin
              sdo_d = tx_q[6];
              tx_d = {tx_q[6:0], 1'b0};
            end
          end
        end
        `SMS_MODE_I2C: begin
          if (i2cStop) begin
            ist_d = sms_pkg::I2C_IDLE;
            sdaOe_d = 1'b0;
          end else if (i2cStart) begin
            ist_d = sms_pkg::I2C_ADDR;
            cnt_d = 6'h00;
            sdaOe_d = 1'b0;
          end else if (ist_q != sms_pkg::I2C_IDLE && sckRise) begin
            if (cnt_q[3:0] != `SMS_ACK_SLOT) begin
              sh_d = {sh_q[30:0], lnk.sda};
              cnt_d = cnt_q + 6'h01;
            end else begin
              cnt_d = 6'h00;
              // own address ack is not a master ack: only judge the slot we released
              if (ist_q == sms_pkg::I2C_RDATA && !sdaOe_q) begin
                nack_d = lnk.sda;
                if (!lnk.sda) begin
                  ptr_d = ptr_q + 16'h0001;
                  regAddr_d = ptr_q + 16'h0001;
                  regRd_d = 1'b1;
                end
              end
            end
          end else if (ist_q != sms_pkg::I2C_IDLE && sckFall) begin
            if (cnt_q[3:0] == `SMS_ACK_SLOT) begin
              sdaOe_d = 1'b1;
              case (ist_q)
                sms_pkg::I2C_ADDR: begin
                  if (rxByte[7:1] == `SMS_I2C_ADDR) begin
                    if (rxByte[0]) begin
                      ist_d = sms_pkg::I2C_RDATA;
                      nack_d = 1'b0;
                      regAddr_d = ptr_q;
                      regRd_d = 1'b1;
                    end else begin
                      ist_d = sms_pkg::I2C_ADDR_HI;
                    end
                  end else begin
                    sdaOe_d = 1'b0;
                    ist_d = sms_pkg::I2C_IDLE;
                  end
                end
                sms_pkg::I2C_ADDR_HI: begin
                  ptr_d[15:8] = rxByte;
                  ist_d = sms_pkg::I2C_ADDR_LO;
                end
                sms_pkg::I2C_ADDR_LO: begin
                  ptr_d[7:0] = rxByte;
                  ist_d = sms_pkg::I2C_WDATA;
                end
                sms_pkg::I2C_WDATA: begin
                  regWr_d = 1'b1;
                  regAddr_d = ptr_q;
                  regWdata_d = rxByte;
                  ptr_d = ptr_q + 16'h0001;
                end
                default: sdaOe_d = 1'b0;
              endcase
            end else if (cnt_q[3:0] == 4'h0) begin
              sdaOe_d = 1'b0;
              if (ist_q == sms_pkg::I2C_RDATA && !nack_q) begin
                tx_d = rdBuf_q;
                sdaOe_d = !rdBuf_q[7];
              end
            end else if (ist_q == sms_pkg::I2C_RDATA && !nack_q) begin
              sdaOe_d = !tx_q[6];
              tx_d = {tx_q[6:0], 1'b0};
            end
          end
        end
        default: begin
          // management frames here only reach phy registers, which live elsewhere
          sdoOe_d = 1'b0;
          sdaOe_d = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // no power-down input: the port keeps running whenever clkEn is high
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_q <= `SMS_MODE_SPI;
      strapDone_q <= 1'b0;
      sckPrev_q <= 1'b0;
      sdaPrev_q <= 1'b1;
      cnt_q <= 6'h00;
      sh_q <= 32'h0000_0000;
      tx_q <= 8'h00;
      ptr_q <= 16'h0000;
      regAddr_q <= 16'h0000;
      regWdata_q <= 8'h00;
      regWr_q <= 1'b0;
      regRd_q <= 1'b0;
      rdBuf_q <= 8'h00;
      isRead_q <= 1'b0;
      isWrite_q <= 1'b0;
      nack_q <= 1'b0;
      sdo_q <= 1'b0;
      sdoOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      ist_q <= sms_pkg::I2C_IDLE;
    end else if (clkEn) begin
      mode_q <= mode_d;
      strapDone_q <= strapDone_d;
      sckPrev_q <= sckPrev_d;
      sdaPrev_q <= sdaPrev_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      regAddr_q <= regAddr_d;
      regWdata_q <= regWdata_d;
      regWr_q <= regWr_d;
      regRd_q <= regRd_d;
      rdBuf_q <= rdBuf_d;
      isRead_q <= isRead_d;
      isWrite_q <= isWrite_d;
      nack_q <= nack_d;
      sdo_q <= sdo_d;
      sdoOe_q <= sdoOe_d;
      sdaOe_q <= sdaOe_d;
      ist_q <= ist_d;
    end
  end

  assign regAddr = regAddr_q;
  assign regWdata = regWdata_q;
  assign regWr = regWr_q;
  assign regRd = regRd_q;
  assign portMode = mode_q;
  assign lnk.devSdo = sdo_q;
  assign lnk.sdoOe = sdoOe_q;
  // open drain: the driven level is always low, sdaOe_q alone decides
  assign lnk.devSdaOut = 1'b0;
  assign lnk.devSdaOe = sdaOe_q;

endmodule : sms_dev_end

`default_nettype wire

// ==== sms_host_end.sv ====
// host end of the serial management port: single-byte spi or i2c master
// assumes the device end follows the same framing; bit rate set by CLK_DIV
`timescale 1ns/10ps
`default_nettype none
`include "sms_params.svh"

module sms_host_end #(
  parameter int CLK_DIV = 4           // clk_sys cycles per bit phase
) (
  input wire logic clk_sys,          // system clock
  input wire logic resetn,           // synchronous reset, active low
  input wire logic clkEn,            // freezes all state while low
  input wire logic useI2c,           // 1 selects i2c framing, 0 spi
  input wire logic cmdValid,         // access request
  input wire logic cmdWrite,         // 1 write, 0 read
  input wire logic [15:0] cmdAddr,   // register address
  input wire logic [7:0] cmdWdata,   // write data
  output logic cmdReady,             // idle, request accepted when high
  output logic rdValid,              // read data valid, one cycle
  output logic [7:0] rdData,         // read data
  output logic ackErr,               // i2c access not acknowledged
  sms_link_if.host lnk               // serial pins
);

  sms_pkg::sms_host_st_t st_q, st_d;
  logic [$clog2(CLK_DIV + 1)-1:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [5:0] bit_q, bit_d;
  logic [2:0] idx_q, idx_d;
  logic [39:0] fr_q, fr_d;
  logic [7:0] rx_q, rx_d;
  logic wr_q, wr_d;
  logic i2c_q, i2c_d;
  logic sck_q, sck_d;
  logic csN_q, csN_d;
  logic sdi_q, sdi_d;
  logic sdaOe_q, sdaOe_d;
  logic ready_q, ready_d;
  logic rdValid_q, rdValid_d;
  logic ackErr_q, ackErr_d;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic [7:0] txByte;
    logic rdByte;
    txByte = 8'hFF;
    tick = (div_q == ($clog2(CLK_DIV + 1))'(CLK_DIV - 1));
    rdByte = !wr_q && idx_q == `SMS_IDX_READ;
    case (idx_q)
      3'h0: txByte = {`SMS_I2C_ADDR, 1'b0};
      `SMS_IDX_ADDR_HI: txByte = fr_q[15:8];
      `SMS_IDX_ADDR_LO: txByte = fr_q[7:0];
      `SMS_IDX_THIRD: txByte = wr_q ? fr_q[23:16] : {`SMS_I2C_ADDR, 1'b1};
      default: txByte = 8'hFF;
    endcase
    st_d = st_q;
    div_d = tick ? '0 : div_q + 1'b1;
    ph_d = ph_q;
    bit_d = bit_q;
    idx_d = idx_q;
    fr_d = fr_q;
    rx_d = rx_q;
    wr_d = wr_q;
    i2c_d = i2c_q;
    sck_d = sck_q;
    csN_d = csN_q;
    sdi_d = sdi_q;
    sdaOe_d = sdaOe_q;
    ready_d = ready_q;
    rdValid_d = 1'b0;
    ackErr_d = ackErr_q;
    if (st_q != sms_pkg::H_IDLE && tick) begin
      ph_d = ph_q + 2'h1;
    end
    case (st_q)
      sms_pkg::H_IDLE: begin
        sck_d = useI2c;
        if (cmdValid && ready_q) begin
          ready_d = 1'b0;
          ackErr_d = 1'b0;
          wr_d = cmdWrite;
          i2c_d = useI2c;
          ph_d = 2'h0;
          bit_d = 6'h00;
          idx_d = 3'h0;
          div_d = '0;
          fr_d = {cmdWrite ? `SMS_CMD_WRITE : `SMS_CMD_READ, `SMS_ADDR_PAD, cmdAddr,
                  `SMS_TA_PAD, cmdWdata};
          if (useI2c) begin
            fr_d = {16'h0000, cmdWdata, cmdAddr};
            st_d = sms_pkg::H_START;
          end else begin
            csN_d = 1'b0;
            st_d = sms_pkg::H_SPI;
          end
        end
      end
      sms_pkg::H_SPI: if (tick) begin
        case (ph_q)
          2'h0: sck_d = 1'b0;
          `SMS_PH_DRIVE: begin
            sdi_d = fr_q[39];
            fr_d = {fr_q[38:0], 1'b0};
          end
          `SMS_PH_RISE: sck_d = 1'b1;
          default: begin
            rx_d = {rx_q[6:0], lnk.sdoLine};
            bit_d = bit_q + 6'h01;
            if (bit_q == `SMS_BYTE_LAST) begin
              st_d = sms_pkg::H_DONE;
            end
          end
        endcase
      end
      sms_pkg::H_START: if (tick) begin
        case (ph_q)
          2'h0: sdaOe_d = 1'b0;
          `SMS_PH_DRIVE: sck_d = 1'b1;
          `SMS_PH_RISE: sdaOe_d = 1'b1;
          default: begin
            sck_d = 1'b0;
            bit_d = 6'h00;
            st_d = sms_pkg::H_BYTE;
          end
        endcase
      end
      sms_pkg::H_BYTE: if (tick) begin
        case (ph_q)
          2'h0: sck_d = 1'b0;
          `SMS_PH_DRIVE: begin
            if (bit_q[3:0] == `SMS_ACK_SLOT) begin
              sdaOe_d = 1'b0;
            end else begin
              sdaOe_d = !rdByte && !txByte[3'h7 - bit_q[2:0]];
            end
          end
          `SMS_PH_RISE: sck_d = 1'b1;
          default: begin
            bit_d = bit_q + 6'h01;
            if (bit_q[3:0] != `SMS_ACK_SLOT) begin
              rx_d = {rx_q[6:0], lnk.sda};
            end else begin
              bit_d = 6'h00;
              idx_d = idx_q + 3'h1;
              if (!rdByte && lnk.sda) begin
                ackErr_d = 1'b1;
                st_d = sms_pkg::H_STOP;
              end else if (rdByte || (wr_q && idx_q == `SMS_IDX_THIRD)) begin
                st_d = sms_pkg::H_STOP;
              end else if (!wr_q && idx_q == `SMS_IDX_ADDR_LO) begin
                // scl must drop before sda is released, or the restart is never seen
                sck_d = 1'b0;
                st_d = sms_pkg::H_START;
              end
            end
          end
        endcase
      end
      sms_pkg::H_STOP: if (tick) begin
        case (ph_q)
          2'h0: sck_d = 1'b0;
          `SMS_PH_DRIVE: sdaOe_d = 1'b1;
          `SMS_PH_RISE: sck_d = 1'b1;
          default: begin
            sdaOe_d = 1'b0;
            st_d = sms_pkg::H_DONE;
          end
        endcase
      end
      sms_pkg::H_DONE: if (tick) begin
        // spi clock returns low in the same cycle that select rises
        sck_d = i2c_q;
        csN_d = 1'b1;
        ready_d = 1'b1;
        rdValid_d = !wr_q && !ackErr_q;
        st_d = sms_pkg::H_IDLE;
      end
      default: st_d = sms_pkg::H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= sms_pkg::H_IDLE;
      div_q <= '0;
      ph_q <= 2'h0;
      bit_q <= 6'h00;
      idx_q <= 3'h0;
      fr_q <= 40'h00_0000_0000;
      rx_q <= 8'h00;
      wr_q <= 1'b0;
      i2c_q <= 1'b0;
      sck_q <= 1'b0;
      csN_q <= 1'b1;
      sdi_q <= 1'b0;
      sdaOe_q <= 1'b0;
      ready_q <= 1'b1;
      rdValid_q <= 1'b0;
      ackErr_q <= 1'b0;
    end else if (clkEn) begin
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      fr_q <= fr_d;
      rx_q <= rx_d;
      wr_q <= wr_d;
      i2c_q <= i2c_d;
      sck_q <= sck_d;
      csN_q <= csN_d;
      sdi_q <= sdi_d;
      sdaOe_q <= sdaOe_d;
      ready_q <= ready_d;
      rdValid_q <= rdValid_d;
      ackErr_q <= ackErr_d;
    end
  end

  assign cmdReady = ready_q;
  assign rdValid = rdValid_q;
  assign rdData = rx_q;
  assign ackErr = ackErr_q;
  assign lnk.sck = sck_q;
  assign lnk.csN = csN_q;
  assign lnk.serial_data_in = sdi_q;
  assign lnk.hostSdaOut = 1'b0;
  assign lnk.hostSdaOe = sdaOe_q;

endmodule : sms_host_end

`default_nettype wire

// ==== sms_link_sva.sv ====
// checker for the serial pins between host end and device end
// assumes it is instantiated beside the link interface by the bench
`timescale 1ns/10ps
`default_nettype none

module sms_link_sva (
  input wire logic clk_sys,  // system clock
  input wire logic resetn,   // synchronous reset, active low
  input wire logic sck,      // serial clock
  input wire logic csN,      // spi select
  input wire logic devSdo,   // device sdo value
  input wire logic sdoOe,    // device drives sdo
  input wire logic devSdaOe  // device pulls sda low
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // sck rise count within a frame
  // ----------------------------------------
  logic sckQ_q;
  logic sckQ_d;
  logic [6:0] riseCnt_q;
  logic [6:0] riseCnt_d;
  always_comb begin
    sckQ_d = resetn ? sck : 1'b0;
    riseCnt_d = riseCnt_q;
    if (!resetn || csN) begin
      riseCnt_d = 7'h00;
    end else if (sck && !sckQ_q && riseCnt_q != 7'h7F) begin
      riseCnt_d = riseCnt_q + 7'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    sckQ_q <= sckQ_d;
    riseCnt_q <= riseCnt_d;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_quiet;
    (!sdoOe && !devSdaOe)[*8];
  endsequence
  property p_frame_open;
    $fell(csN) |-> s_quiet;
  endproperty
  property p_sdo_idle;
    csN && $past(csN) |-> !sdoOe;
  endproperty
  property p_sdo_late;
    sdoOe && !csN |-> riseCnt_q >= 7'h20;
  endproperty
  property p_frame_len;
    $rose(csN) |-> riseCnt_q == 7'h28;
  endproperty
  property p_sdo_fall;
    sdoOe && $past(sdoOe) && $changed(devSdo) |-> !sck;
  endproperty
  property p_sdo_hold;
    sck && $past(sck) && sdoOe && $past(sdoOe) |-> $stable(devSdo);
  endproperty
  property p_sck_idle;
    $rose(csN) || $fell(csN) |-> !sck;
  endproperty
  property p_spi_no_sda;
    !csN |-> !devSdaOe;
  endproperty
  property p_ack_low;
    $changed(devSdaOe) |-> !sck;
  endproperty

  a_frame_open: assert property (p_frame_open) else $error("sdo or sda driven early");
  a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while idle");
  a_sdo_late: assert property (p_sdo_late) else $error("sdo before data phase");
  a_frame_len: assert property (p_frame_len) else $error("frame not 40 clocks");
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved with sck high");
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo unstable at sample");
  a_sck_idle: assert property (p_sck_idle) else $error("sck high at select edge");
  a_spi_no_sda: assert property (p_spi_no_sda) else $error("sda driven in spi");
  a_ack_low: assert property (p_ack_low) else $error("sda moved with scl high");
endmodule : sms_link_sva

`default_nettype wire

// ==== tb_serial_mgmt_slave_port.sv ====
// bench: host end and device end joined by the link interface
// assumes a byte memory model answers the device register strobes
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb_serial_mgmt_slave_port;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] modeStrap = 2'h0;
  logic useI2c = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [15:0] cmdAddr = 16'h0000;
  logic [7:0] cmdWdata = 8'h00;
  logic [15:0] regAddr, wrAddr;
  logic [7:0] regWdata, regRdata, rdData, wrData, rdSeen;
  logic regWr, regRd, cmdReady, rdValid, ackErr;
  logic [1:0] portMode;
  logic [7:0] mem [0:255];
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int wrCount = 0;

  sms_link_if lnkIf();
  sms_dev_end sms_dev_end_i (.clk_sys(clk_sys), .resetn(resetn), .clkEn(1'b1),
    .modeStrap(modeStrap), .regRdata(regRdata), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .portMode(portMode), .lnk(lnkIf));
  sms_host_end #(.CLK_DIV(4)) sms_host_end_i (.clk_sys(clk_sys), .resetn(resetn),
    .clkEn(1'b1), .useI2c(useI2c), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady), .rdValid(rdValid),
    .rdData(rdData), .ackErr(ackErr), .lnk(lnkIf));
  sms_link_sva sms_link_sva_i (.clk_sys(clk_sys), .resetn(resetn), .sck(lnkIf.sck),
    .csN(lnkIf.csN), .devSdo(lnkIf.devSdo), .sdoOe(lnkIf.sdoOe),
    .devSdaOe(lnkIf.devSdaOe));

  assign regRdata = mem[regAddr[7:0]];
  always #5 clk_sys = ~clk_sys;

  // register memory and capture; cycle ceiling cuts a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (regWr) begin
      mem[regAddr[7:0]] <= regWdata;
      wrAddr <= regAddr;
      wrData <= regWdata;
      wrCount <= wrCount + 1;
    end
    if (rdValid) rdSeen <= rdData;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task do_reset(input logic [1:0] m);
    modeStrap <= m;
    useI2c <= (m == 2'h1);
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset

  task access(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmdWrite <= wr;
    cmdAddr <= a;
    cmdWdata <= d;
    cmdValid <= 1'b1;
    // request stands until an edge at which the host reports ready
    do @(posedge clk_sys); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    @(posedge clk_sys);
    while (cmdReady !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 5000) fails++;
    // one more edge lets the capture of rdData settle
    @(posedge clk_sys);
  endtask : access

  task t_spi;
    do_reset(2'h0);
    `CHK("portMode", 2'h0, portMode)
    access(1'b1, 16'h1234, 8'h5A);
    `CHK("wrAddr", 16'h1234, wrAddr)
    `CHK("wrData", 8'h5A, wrData)
    access(1'b1, 16'hAB07, 8'hC3);
    `CHK("wrCount", 2, wrCount)
    access(1'b0, 16'h1234, 8'h00);
    `CHK("rdSeen", 8'h5A, rdSeen)
    modeStrap <= 2'h1;
    repeat (4) @(posedge clk_sys);
    `CHK("portMode", 2'h0, portMode)
    $display("spi test done");
  endtask : t_spi

  task t_i2c;
    do_reset(2'h1);
    `CHK("portMode", 2'h1, portMode)
    access(1'b1, 16'h2211, 8'h96);
    `CHK("wrAddr", 16'h2211, wrAddr)
    `CHK("wrData", 8'h96, wrData)
    `CHK("ackErr", 1'b0, ackErr)
    access(1'b0, 16'h2211, 8'h00);
    `CHK("rdSeen", 8'h96, rdSeen)
    $display("i2c test done");
  endtask : t_i2c

  task t_miim;
    int c0;
    do_reset(2'h2);
    c0 = wrCount;
    access(1'b1, 16'h0040, 8'h11);
    `CHK("wrCount", c0, wrCount)
    useI2c <= 1'b1;
    repeat (4) @(posedge clk_sys);
    access(1'b1, 16'h0041, 8'h22);
    `CHK("ackErr", 1'b1, ackErr)
    `CHK("wrCount", c0, wrCount)
    $display("miim test done");
  endtask : t_miim

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  initial begin
    t_spi();
    t_i2c();
    t_miim();
    close_out();
  end
endmodule : tb_serial_mgmt_slave_port

`default_nettype wire
